/* design/world_pkg.sv */
package world_pkg;

  // Processor mode encodings
  typedef logic [4:0] mode_t;
  localparam mode_t MODE_USR = 5'h10;
  localparam mode_t MODE_FIQ = 5'h11;
  localparam mode_t MODE_IRQ = 5'h12;
  localparam mode_t MODE_SUP = 5'h13;
  localparam mode_t MODE_MON = 5'h16;
  localparam mode_t MODE_ABT = 5'h17;
  localparam mode_t MODE_UND = 5'h1B;
  localparam mode_t MODE_SYS = 5'h1F;

  // Security configuration register layout
  localparam int CFG_W        = 3;
  localparam int CFG_WSEL_BIT = 0;
  localparam int CFG_IRQ_BIT  = 1;
  localparam int CFG_FIQ_BIT  = 2;
  localparam logic [CFG_W-1:0] CFG_RESET = 3'h0;

  // Status word layout: mode field in the low bits
  localparam int MODE_LSB = 0;
  localparam int MODE_W   = 5;
  localparam logic [31:0] STATUS_RESET = 32'h000001D3;

  // Banked context defaults
  localparam int CTX_DEPTH    = 8;
  localparam int CTX_WIDTH    = 32;
  localparam int IMM_W        = 16;
  localparam logic [31:0] ADDR_RESET = 32'h00000000;

  // Retired operation kinds from the decoder
  typedef enum logic [2:0] {
    OP_NONE   = 3'h0,
    OP_MCALL  = 3'h1,
    OP_SCALL  = 3'h2,
    OP_FMOVE  = 3'h3,
    OP_FSUB   = 3'h4,
    OP_XRET   = 3'h5,
    OP_STWR   = 3'h6,
    OP_CFG_WR = 3'h7
  } op_e;

  typedef struct packed {
    logic              valid;
    op_e               op;
    logic              cond_pass;
    logic [IMM_W-1:0]  imm;
    logic [31:0]       ret_addr;
    logic [31:0]       data;
  } retire_s;

  typedef struct packed {
    logic        take;
    logic        to_monitor;
    logic        undef;
    logic        flush;
    mode_t       mode;
  } event_s;

endpackage

/* design/ctx_bank.sv */
`timescale 1ns/10ps
module ctx_bank
  import world_pkg::*;
#(
  parameter int WIDTH = CTX_WIDTH,
  parameter int DEPTH = CTX_DEPTH,
  parameter int AW    = $clog2(DEPTH)
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic             clock_en,
  // Access
  input  wire logic             world,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    idx,
  input  wire logic [WIDTH-1:0] wdata,
  output logic      [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem_r [2*DEPTH];
  logic [AW:0]      addr;

  assign addr = {world, idx};

  always_ff @(posedge clock) begin
    if (clock_en && wr_en) begin
      mem_r[addr] <= wdata;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= '0;
    end else if (clock_en) begin
      rdata <= mem_r[addr];
    end
  end

endmodule

/* design/secure_world_switch_control.sv */
// Operation
// - world taken from world-select bit, except monitor mode
// - non-monitor modes run in either world
// - monitor mode privileged and always secure
// - banked coprocessor context follows active world
// - monitor call enters monitor mode
// - monitor call only from privileged modes
// - monitor call obeys its condition
// - monitor call immediate captured as service select
// - flag-setting move of link returns, from monitor mode only
// - prefetch after return never keeps secure rights
// - status write may keep stale secure prefetch
// - any secure privileged mode writes world bit
// - reset into secure supervisor, bit clear
// - routed interrupts enter monitor mode
// - bus protection bit shows access security
`timescale 1ns/10ps
module secure_world_switch_control
  import world_pkg::*;
#(
  parameter int CTX_D = CTX_DEPTH,
  parameter int CTX_A = $clog2(CTX_DEPTH)
) (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 reset_n,
  input  wire logic                 clock_en,
  // Retired instruction
  input  wire retire_s              retire,
  input  wire logic [31:0]          cur_status,
  // Interrupt requests
  input  wire logic                 irq_req,
  input  wire logic                 fiq_req,
  // Barrier completion
  input  wire logic                 barrier_done,
  // Banked coprocessor context
  input  wire logic                 ctx_wr,
  input  wire logic [CTX_A-1:0]     ctx_idx,
  input  wire logic [CTX_WIDTH-1:0] ctx_wdata,
  output logic      [CTX_WIDTH-1:0] ctx_rdata,
  // Security state
  output mode_t                     mode,
  output logic                      world_nonsecure,
  output logic                      fetch_nonsecure,
  output logic                      bus_prot_ns,
  output logic [CFG_W-1:0]          cfg_value,
  // Monitor banked registers
  output logic [31:0]               monitor_link_register,
  output logic [31:0]               monitor_saved_status,
  output logic [IMM_W-1:0]          service_select,
  // Events
  output event_s                    evt
);

  ////////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic logic is_priv(input mode_t m);
    return m != MODE_USR;
  endfunction

  function automatic logic is_secure(input mode_t m, input logic ns);
    return (m == MODE_MON) || !ns;
  endfunction

  function automatic logic is_return(input op_e o);
    return (o == OP_FMOVE) || (o == OP_FSUB) || (o == OP_XRET);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef enum logic [1:0] {
    ST_RUN   = 2'b01,
    ST_STALE = 2'b10
  } fetch_e;

  mode_t            mode_r;
  mode_t            mode_nxt;
  logic [CFG_W-1:0] cfg_r;
  logic [CFG_W-1:0] cfg_nxt;
  logic [31:0]      lr_r;
  logic [31:0]      spsr_r;
  logic [IMM_W-1:0] sel_r;
  logic             fetch_ns_r;
  fetch_e           fst_r;
  fetch_e           fst_nxt;
  event_s           evt_r;
  event_s           evt_nxt;
  logic             act;
  logic             priv;
  logic             secure_now;
  logic             mcall_go;
  logic             ret_go;
  logic             irq_go;
  logic             fiq_go;
  mode_t            ret_mode;

  assign act        = retire.valid && retire.cond_pass;
  assign priv       = is_priv(mode_r);
  assign ret_mode   = mode_t'(spsr_r[MODE_LSB +: MODE_W]);
  assign secure_now = is_secure(mode_r, cfg_r[CFG_WSEL_BIT]);
  assign mcall_go   = act && retire.op == OP_MCALL && priv;
  assign ret_go     = act && is_return(retire.op) && mode_r == MODE_MON;
  assign fiq_go     = fiq_req;
  assign irq_go     = irq_req && !fiq_req;

  ////////////////////////////////////////////////////////////////////////
  // Next mode and event

  always_comb begin
    mode_nxt          = mode_r;
    evt_nxt           = '0;
    evt_nxt.mode      = mode_r;
    cfg_nxt           = cfg_r;
    if (fiq_go || irq_go) begin
      evt_nxt.take = 1'b1;
      if ((fiq_go && cfg_r[CFG_FIQ_BIT]) || (irq_go && cfg_r[CFG_IRQ_BIT])) begin
        mode_nxt           = MODE_MON;
        evt_nxt.to_monitor = 1'b1;
      end else begin
        mode_nxt = fiq_go ? MODE_FIQ : MODE_IRQ;
      end
    end else if (act) begin
      unique case (retire.op)
        OP_MCALL: begin
          if (mcall_go) begin
            mode_nxt           = MODE_MON;
            evt_nxt.take       = 1'b1;
            evt_nxt.to_monitor = 1'b1;
          end else begin
            mode_nxt      = MODE_UND;
            evt_nxt.take  = 1'b1;
            evt_nxt.undef = 1'b1;
          end
        end
        OP_SCALL: begin
          mode_nxt     = MODE_SUP;
          evt_nxt.take = 1'b1;
        end
        OP_FMOVE, OP_FSUB, OP_XRET: begin
          if (ret_go) begin
            mode_nxt      = ret_mode;
            evt_nxt.flush = 1'b1;
          end
        end
        OP_CFG_WR: begin
          if (priv && secure_now) begin
            cfg_nxt = retire.data[CFG_W-1:0];
          end else begin
            mode_nxt      = MODE_UND;
            evt_nxt.take  = 1'b1;
            evt_nxt.undef = 1'b1;
          end
        end
        OP_STWR: begin
          if (priv) begin
            mode_nxt = mode_t'(retire.data[MODE_LSB +: MODE_W]);
          end
        end
        OP_NONE: begin
          mode_nxt = mode_r;
        end
      endcase
    end
    evt_nxt.mode = mode_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode register

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mode_r <= MODE_SUP;
    end else if (clock_en) begin
      mode_r <= mode_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Security configuration register

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cfg_r <= CFG_RESET;
    end else if (clock_en) begin
      cfg_r <= cfg_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Monitor link and saved status

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      lr_r   <= ADDR_RESET;
      spsr_r <= STATUS_RESET;
    end else if (clock_en && evt_nxt.to_monitor) begin
      lr_r   <= retire.ret_addr;
      spsr_r <= cur_status;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sel_r <= '0;
    end else if (clock_en && mcall_go && !(fiq_go || irq_go)) begin
      sel_r <= retire.imm;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Fetch permission tracking

  always_comb begin
    fst_nxt = fst_r;
    unique case (fst_r)
      ST_RUN: begin
        if (act && retire.op == OP_STWR && priv) begin
          fst_nxt = ST_STALE;
        end else if (cfg_nxt != cfg_r && !evt_nxt.flush) begin
          fst_nxt = ST_STALE;
        end
      end
      ST_STALE: begin
        if (barrier_done || evt_nxt.flush || evt_nxt.take) begin
          fst_nxt = ST_RUN;
        end
      end
      default: fst_nxt = ST_RUN;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      fst_r      <= ST_RUN;
      fetch_ns_r <= 1'b0;
    end else if (clock_en) begin
      fst_r <= fst_nxt;
      if (fst_nxt == ST_RUN) begin
        fetch_ns_r <= !is_secure(mode_nxt, cfg_nxt[CFG_WSEL_BIT]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Event register

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      evt_r      <= '0;
      evt_r.mode <= MODE_SUP;
    end else if (clock_en) begin
      evt_r <= evt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Banked context

  ctx_bank #(
    .WIDTH (CTX_WIDTH),
    .DEPTH (CTX_D),
    .AW    (CTX_A)
  ) u_bank (
    .clock   (clock),
    .reset_n (reset_n),
    .clock_en(clock_en),
    .world   (!secure_now),
    .wr_en   (ctx_wr),
    .idx     (ctx_idx),
    .wdata   (ctx_wdata),
    .rdata   (ctx_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign mode                  = mode_r;
  assign world_nonsecure       = !secure_now;
  assign fetch_nonsecure       = fetch_ns_r;
  assign bus_prot_ns           = !secure_now;
  assign cfg_value             = cfg_r;
  assign monitor_link_register = lr_r;
  assign monitor_saved_status  = spsr_r;
  assign service_select        = sel_r;
  assign evt                   = evt_r;

endmodule

/* verification/secure_world_switch_control_asserts.sv */
`timescale 1ns/10ps
module secure_world_switch_control_asserts
  import world_pkg::*;
(
  // Clock and reset
  input wire logic             clock,
  input wire logic             reset_n,
  input wire logic             clock_en,
  // Stimulus side
  input wire retire_s          retire,
  input wire logic [31:0]      cur_status,
  input wire logic             irq_req,
  input wire logic             fiq_req,
  // Security state
  input wire mode_t            mode,
  input wire logic             world_nonsecure,
  input wire logic             fetch_nonsecure,
  input wire logic             bus_prot_ns,
  input wire logic [CFG_W-1:0] cfg_value,
  input wire logic [31:0]      monitor_link_register,
  input wire logic [31:0]      monitor_saved_status,
  input wire event_s           evt
);
  ////////////////////////////////////////////////////////////////////////////
  wire logic        acc;
  wire logic [31:0] ret_addr;
  wire logic [4:0]  saved_mode;
  assign acc        = clock_en & retire.valid & retire.cond_pass & ~irq_req & ~fiq_req;
  assign ret_addr   = retire.ret_addr;
  assign saved_mode = monitor_saved_status[4:0];

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence s_mcall_priv; acc && retire.op == OP_MCALL && mode != MODE_USR; endsequence
  sequence s_mcall_user; acc && retire.op == OP_MCALL && mode == MODE_USR; endsequence
  sequence s_enter; mode == MODE_MON && evt.take && evt.to_monitor; endsequence
  sequence s_ret; acc && retire.op == OP_FMOVE && mode == MODE_MON; endsequence

  ////////////////////////////////////////////////////////////////////////////
  AST_MON_SECURE: assert property (
    mode == MODE_MON |-> !world_nonsecure) else $error("monitor mode non-secure");
  AST_WORLD_BIT: assert property (
    mode != MODE_MON |-> world_nonsecure == cfg_value[CFG_WSEL_BIT]) else $error("world mismatch");
  AST_BUS_PROT: assert property (
    bus_prot_ns == world_nonsecure) else $error("bus protection bit wrong");
  AST_MCALL_ENTER: assert property (
    s_mcall_priv |=> s_enter) else $error("monitor call did not enter monitor");
  AST_MCALL_SAVE: assert property (
    s_mcall_priv |=> monitor_link_register == $past(ret_addr)
    && monitor_saved_status == $past(cur_status)) else $error("link or status not saved");
  AST_MCALL_USER: assert property (
    s_mcall_user |=> mode == MODE_UND && evt.undef) else $error("user monitor call not refused");
  AST_MCALL_COND: assert property (
    clock_en && retire.valid && retire.op == OP_MCALL && !retire.cond_pass && !irq_req
    && !fiq_req |=> $stable(mode) && !evt.take) else $error("failed condition took effect");
  AST_RETURN: assert property (
    s_ret |=> mode == $past(saved_mode) && evt.flush) else $error("return mode wrong");
  AST_RET_FETCH: assert property (
    s_ret |=> fetch_nonsecure == world_nonsecure) else $error("stale fetch rights after return");
  AST_FIQ_ROUTE: assert property (
    clock_en && fiq_req && cfg_value[CFG_FIQ_BIT] |=> mode == MODE_MON) else $error("fiq not routed");
endmodule

bind secure_world_switch_control secure_world_switch_control_asserts u_chk (
  .clock, .reset_n, .clock_en, .retire, .cur_status, .irq_req, .fiq_req, .mode,
  .world_nonsecure, .fetch_nonsecure, .bus_prot_ns, .cfg_value, .monitor_link_register,
  .monitor_saved_status, .evt
);

/* verification/secure_world_switch_control_tb.sv */
`timescale 1ns/10ps
module secure_world_switch_control_tb
  import world_pkg::*;
;
  logic             clock;
  logic             reset_n;
  logic             clock_en;
  logic             barrier_done;
  retire_s          retire;
  logic [31:0]      cur_status;
  logic             irq_req;
  logic             fiq_req;
  logic             ctx_wr;
  logic [2:0]       ctx_idx;
  logic [31:0]      ctx_wdata;
  logic [31:0]      ctx_rdata;
  mode_t            mode;
  logic             world_nonsecure;
  logic             fetch_nonsecure;
  logic             bus_prot_ns;
  logic [CFG_W-1:0] cfg_value;
  logic [31:0]      monitor_link_register;
  logic [31:0]      monitor_saved_status;
  logic [IMM_W-1:0] service_select;
  event_s           evt;
  int               n_mismatch = 0;
  int               checks = 0;

  secure_world_switch_control uut (
    .clock, .reset_n, .clock_en, .retire, .cur_status, .irq_req, .fiq_req,
    .barrier_done, .ctx_wr, .ctx_idx, .ctx_wdata, .ctx_rdata, .mode, .world_nonsecure,
    .fetch_nonsecure, .bus_prot_ns, .cfg_value, .monitor_link_register,
    .monitor_saved_status, .service_select, .evt
  );

  always #50 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp(string n, logic [31:0] e, logic [31:0] s);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic step(op_e o, logic cp, logic [31:0] d);
    @(negedge clock);
    retire = '{1'b1, o, cp, 16'hA5C3, 32'h0000_1234, d};
    @(negedge clock);
    retire.valid = 1'b0;
  endtask

  task automatic pulse(ref logic s);
    @(negedge clock);
    s = 1'b1;
    @(negedge clock);
    s = 1'b0;
  endtask

  task automatic ctx_put(logic [31:0] d);
    @(negedge clock);
    ctx_wr = 1'b1;
    ctx_wdata = d;
    @(negedge clock);
    ctx_wr = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    cmp("mode", MODE_SUP, mode);
    cmp("cfg", CFG_RESET, cfg_value);
    cmp("world", 0, world_nonsecure);
  endtask

  task automatic t_enter();
    cur_status = 32'h0000_0010;
    step(OP_MCALL, 1'b0, 0);
    cmp("mode", MODE_SUP, mode);
    ctx_put(32'hAAAA_0001);
    step(OP_MCALL, 1'b1, 0);
    cmp("mode", MODE_MON, mode);
    cmp("take", 1, evt.take);
    cmp("link", 32'h0000_1234, monitor_link_register);
    cmp("spsr", 32'h0000_0010, monitor_saved_status);
    cmp("select", 16'hA5C3, service_select);
  endtask

  task automatic t_route();
    step(OP_CFG_WR, 1'b1, 32'h4);
    cmp("cfg", 3'h4, cfg_value);
    pulse(fiq_req);
    cmp("mode", MODE_MON, mode);
    step(OP_CFG_WR, 1'b1, 32'h1);
    cmp("world", 0, world_nonsecure);
  endtask

  task automatic t_return();
    step(OP_FMOVE, 1'b1, 0);
    cmp("mode", MODE_USR, mode);
    cmp("flush", 1, evt.flush);
    cmp("world", 1, world_nonsecure);
    cmp("prot", 1, bus_prot_ns);
    cmp("fetch", 1, fetch_nonsecure);
    ctx_put(32'h5555_0002);
    repeat (2) @(negedge clock);
    cmp("ctx_ns", 32'h5555_0002, ctx_rdata);
  endtask

  task automatic t_user();
    step(OP_MCALL, 1'b1, 0);
    cmp("mode", MODE_UND, mode);
    cmp("undef", 1, evt.undef);
    pulse(irq_req);
    cmp("mode", MODE_IRQ, mode);
    cmp("world", 1, world_nonsecure);
    step(OP_MCALL, 1'b1, 0);
    cmp("mode", MODE_MON, mode);
    repeat (2) @(negedge clock);
    cmp("ctx_s", 32'hAAAA_0001, ctx_rdata);
  endtask

  task automatic t_barrier();
    step(OP_STWR, 1'b1, 32'h13);
    cmp("world", 1, world_nonsecure);
    cmp("fetch", 0, fetch_nonsecure);
    pulse(barrier_done);
    cmp("fetch", 1, fetch_nonsecure);
    clock_en = 1'b0;
    step(OP_MCALL, 1'b1, 0);
    cmp("mode", MODE_SUP, mode);
    clock_en = 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    reset_n = 1'b0;
    clock_en = 1'b1;
    barrier_done = 1'b0;
    retire = '0;
    cur_status = 32'h0;
    irq_req = 1'b0;
    fiq_req = 1'b0;
    ctx_wr = 1'b0;
    ctx_idx = 3'h7;
    ctx_wdata = 32'h0;
    repeat (12) @(negedge clock);
    reset_n = 1'b1;
    t_reset();
    t_enter();
    t_route();
    t_return();
    t_user();
    t_barrier();
    end_sim();
  end

  // Tests need well under 100 cycles
  initial begin
    #100000;
    n_mismatch++;
    end_sim();
  end
endmodule
